// *** phy_led_pkg.sv ***
// constants and types shared by the status indicator driver
package phy_led_pkg;
  localparam int REF_CLK_HZ = 25_000_000;
  localparam int CORE_CLK_HZ = 50_000_000;
  localparam int BLINK_TIME_MS = 80;
  // reference clock cycles in one blink interval
  localparam int BLINK_REF_CYCLES = (REF_CLK_HZ / 1000) * BLINK_TIME_MS;
  // core clock cycles per reference clock cycle
  localparam int CORE_PER_REF = CORE_CLK_HZ / REF_CLK_HZ;
  localparam int CNT_W = 21;
  localparam int REF_DIV_W = 2;
  localparam logic [REF_DIV_W-1:0] REF_DIV_LAST = REF_DIV_W'(CORE_PER_REF - 1);
  localparam int SYNC_STAGES = 3;
  localparam int CONFIG_W = 3;
  localparam logic [CONFIG_W-1:0] CONFIG_RESET = 3'h0;
  localparam logic LED_ON = 1'b0;
  localparam logic LED_OFF = 1'b1;
  localparam int CH_COLLISION = 0;
  localparam int CH_ACTIVITY = 1;
  localparam int NUM_CH = 2;
  typedef enum logic [1:0] {BLINK_IDLE, BLINK_PULSE, BLINK_GAP} blink_state_type;
endpackage

// *** phy_status_led_driver.sv ***
// status indicator driver: duplex/collision, speed and link/activity lamps
//
// Behaviour
// - Duplex/collision lamp low on full-duplex link, high in half-duplex.
// - Half-duplex collision drives lamp low 80 ms, then high at least 80 ms.
// - Speed lamp low at 100 Mbps with link up, high at 10 Mbps or with link down.
// - Link/activity lamp low while link up, high while link failed.
// - With link up, activity pulses link/activity lamp high (off) for 80 ms.
// - After each pulse lamp stays low 80 ms before activity may pulse again.
// - Reset holds the block; power-on settings are caught at reset release.
// - Interval timing runs from the 25 MHz reference time base.
// - Test clock select swaps the reference time base for the test clock.

`timescale 1ns/100ps
module phy_status_led_driver #(
  parameter logic [phy_led_pkg::CNT_W-1:0] BLINK_TICKS =
    phy_led_pkg::CNT_W'(phy_led_pkg::BLINK_REF_CYCLES)
) (
  input wire logic CORE_CLK, // core clock
  input wire logic RST, // synchronous reset, active high
  input wire logic LINK_UP, // phy link established
  input wire logic FULL_DUPLEX, // phy runs full duplex
  input wire logic SPEED_100, // phy runs at 100 Mbps
  input wire logic COLLISION, // phy collision seen
  input wire logic TX_ACTIVITY, // transmit activity seen
  input wire logic RX_ACTIVITY, // receive activity seen
  input wire logic TEST_CLOCK_IN, // test clock pin
  input wire logic TEST_CLOCK_SELECT, // test clock select pin
  input wire logic [phy_led_pkg::CONFIG_W-1:0] CONFIG_IN, // power-on setting pins
  output logic FULL_COLLISION_LED_N, // duplex/collision lamp, low lit
  output logic SPEED_LED_N, // speed lamp, low lit
  output logic LINK_ACTIVITY_LED_N, // link/activity lamp, low lit
  output logic [phy_led_pkg::CONFIG_W-1:0] CONFIG // captured power-on setting
);
  import phy_led_pkg::*;

  localparam logic [CNT_W-1:0] BLINK_LAST = BLINK_TICKS - CNT_W'(1);

  logic [SYNC_STAGES-1:0] test_clock_in_sync;
  logic [SYNC_STAGES-1:0] tsel_sync;

  // settled levels of the two test pins
  logic test_clock_in_level;
  logic tsel_level;
  logic test_clock_in_rise;

  // time base
  logic [REF_DIV_W-1:0] ref_div;
  logic ref_tick;
  logic tick;

  // reset release marker for the setting capture
  logic in_reset;

  // per channel blink controls
  logic [NUM_CH-1:0] chan_event;
  logic [NUM_CH-1:0] chan_enable;
  logic [NUM_CH-1:0] chan_pulse;

  // pin synchronisers; a change counts once second and third stages agree
  // the first stage may go metastable, so only the later stages are read
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      test_clock_in_sync <= '0;
      tsel_sync <= '0;
    end else begin
      test_clock_in_sync <= {test_clock_in_sync[SYNC_STAGES-2:0], TEST_CLOCK_IN};
      tsel_sync <= {tsel_sync[SYNC_STAGES-2:0], TEST_CLOCK_SELECT};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      test_clock_in_level <= 1'b0;
      tsel_level <= 1'b0;
    end else begin
      if (test_clock_in_sync[1] == test_clock_in_sync[2]) begin
        test_clock_in_level <= test_clock_in_sync[1];
      end
      if (tsel_sync[1] == tsel_sync[2]) begin
        tsel_level <= tsel_sync[1];
      end
    end
  end

  // one cycle strobe per settled rising edge of the test clock pin;
  // the level resets to the pin's idle low so no false edge follows reset
  assign test_clock_in_rise = test_clock_in_sync[1] & test_clock_in_sync[2] & ~test_clock_in_level;

  // reference time base derived from the core clock
  // one tick every CORE_PER_REF core cycles stands for one reference cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ref_div <= '0;
    end else if (ref_div == REF_DIV_LAST) begin
      ref_div <= '0;
    end else begin
      ref_div <= ref_div + REF_DIV_W'(1);
    end
  end

  assign ref_tick = (ref_div == REF_DIV_LAST);

  // test select swaps the time base without muxing clocks; the core clock
  // must run well above the test clock for every edge to be seen
  assign tick = tsel_level ? test_clock_in_rise : ref_tick;

  // power-on settings are taken in the first cycle after reset releases
  // in_reset has no reset branch: it simply follows the reset input
  always_ff @(posedge CORE_CLK) begin
    in_reset <= RST;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      CONFIG <= CONFIG_RESET;
    end else if (in_reset) begin
      CONFIG <= CONFIG_IN;
    end
  end

  // blink channels: collision on a half-duplex link, activity on any link
  assign chan_event[CH_COLLISION] = COLLISION;
  assign chan_enable[CH_COLLISION] = LINK_UP & ~FULL_DUPLEX;
  assign chan_event[CH_ACTIVITY] = TX_ACTIVITY | RX_ACTIVITY;
  assign chan_enable[CH_ACTIVITY] = LINK_UP;

  // each channel walks idle, pulse, gap; pulse and gap last BLINK_TICKS ticks
  // losing the enable drops the channel back to idle at once
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_blink
    blink_state_type state;
    logic [CNT_W-1:0] count;


    always_ff @(posedge CORE_CLK) begin
      if (RST || !chan_enable[g]) begin
        state <= BLINK_IDLE;
        count <= '0;
      end else begin
        case (state)
          BLINK_IDLE: begin
            // events are taken only here, never remembered from a pulse or gap
            count <= '0;
            if (chan_event[g]) begin
              state <= BLINK_PULSE;
            end
          end
          BLINK_PULSE: begin
            // count runs 0 to BLINK_LAST, one step per time base tick
            if (tick) begin
              if (count == BLINK_LAST) begin
                state <= BLINK_GAP;
                count <= '0;
              end else begin
                count <= count + CNT_W'(1);
              end
            end
          end
          BLINK_GAP: begin
            // events in the gap are ignored; the lamp holds its steady level
            if (tick) begin
              if (count == BLINK_LAST) begin
                state <= BLINK_IDLE;
                count <= '0;
              end else begin
                count <= count + CNT_W'(1);
              end
            end
          end
          default: begin
            state <= BLINK_IDLE;
            count <= '0;
          end
        endcase
      end
    end


    assign chan_pulse[g] = (state == BLINK_PULSE);
  end

  // lamp outputs
  // every lamp is registered so the pins never carry decode glitches
  // link down darkens the duplex and activity lamps whatever the phy reports
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      FULL_COLLISION_LED_N <= LED_OFF;
    end else if (!LINK_UP) begin
      FULL_COLLISION_LED_N <= LED_OFF;
    end else if (FULL_DUPLEX) begin
      FULL_COLLISION_LED_N <= LED_ON;
    end else begin
      FULL_COLLISION_LED_N <= chan_pulse[CH_COLLISION] ? LED_ON : LED_OFF;
    end
  end

  // speed is meaningless without a link, so the lamp stays dark then
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      SPEED_LED_N <= LED_OFF;
    end else begin
      SPEED_LED_N <= (LINK_UP && SPEED_100) ? LED_ON : LED_OFF;
    end
  end

  // activity blinks the lamp off; between pulses it shows the steady link
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      LINK_ACTIVITY_LED_N <= LED_OFF;
    end else if (!LINK_UP) begin
      LINK_ACTIVITY_LED_N <= LED_OFF;
    end else begin
      LINK_ACTIVITY_LED_N <= chan_pulse[CH_ACTIVITY] ? LED_OFF : LED_ON;
    end
  end
endmodule

// *** phy_led_asserts.sv ***
// port assertions for the status indicator driver
`timescale 1ns/100ps
module phy_led_asserts #(
  parameter logic [20:0] BLINK_TICKS = 21'h4
) (
  input wire logic CORE_CLK, // clock
  input wire logic RST, // reset
  input wire logic LINK_UP, // link
  input wire logic FULL_DUPLEX, // duplex
  input wire logic SPEED_100, // speed
  input wire logic TEST_CLOCK_SELECT, // test time base select
  input wire logic [2:0] CONFIG_IN, // setting pins
  input wire logic FULL_COLLISION_LED_N, // lamp
  input wire logic SPEED_LED_N, // lamp
  input wire logic LINK_ACTIVITY_LED_N, // lamp
  input wire logic [2:0] CONFIG // setting
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff RST;
  // repeat counts assume BLINK_TICKS of 4, two core cycles per tick
  a_reset_off: assert property ($fell(RST) |->
    &{FULL_COLLISION_LED_N, SPEED_LED_N, LINK_ACTIVITY_LED_N}) else $error("lamp lit in reset");
  a_config_cap: assert property ($fell(RST) |=> CONFIG == $past(CONFIG_IN))
    else $error("setting not caught");
  a_link_off: assert property (!LINK_UP |=> LINK_ACTIVITY_LED_N && FULL_COLLISION_LED_N)
    else $error("lamp lit on link down");
  a_speed_lamp: assert property (LINK_UP |=> SPEED_LED_N != $past(SPEED_100))
    else $error("speed lamp wrong");
  a_full_lamp: assert property (LINK_UP && FULL_DUPLEX |=> !FULL_COLLISION_LED_N)
    else $error("full lamp dark");
  a_col_pulse: assert property (disable iff (RST || TEST_CLOCK_SELECT || !LINK_UP || FULL_DUPLEX)
    $fell(FULL_COLLISION_LED_N) |-> !FULL_COLLISION_LED_N [*7] ##[1:3] FULL_COLLISION_LED_N)
    else $error("collision pulse length");
  a_col_gap: assert property (disable iff (RST || TEST_CLOCK_SELECT || !LINK_UP || FULL_DUPLEX)
    $rose(FULL_COLLISION_LED_N) |-> FULL_COLLISION_LED_N [*7]) else $error("collision gap");
  a_act_pulse: assert property (disable iff (RST || TEST_CLOCK_SELECT || !LINK_UP)
    $rose(LINK_ACTIVITY_LED_N) |-> LINK_ACTIVITY_LED_N [*7] ##[1:3] !LINK_ACTIVITY_LED_N)
    else $error("activity pulse length");
  a_act_gap: assert property (disable iff (RST || TEST_CLOCK_SELECT)
    $fell(LINK_ACTIVITY_LED_N) && $past(LINK_UP, 2) && !$past(RST, 2) |->
    !LINK_ACTIVITY_LED_N [*7]) else $error("activity gap");
endmodule
bind phy_status_led_driver phy_led_asserts #(.BLINK_TICKS(BLINK_TICKS)) u_chk (.CORE_CLK,
  .RST, .LINK_UP, .FULL_DUPLEX, .SPEED_100, .TEST_CLOCK_SELECT, .CONFIG_IN,
  .FULL_COLLISION_LED_N, .SPEED_LED_N,
  .LINK_ACTIVITY_LED_N, .CONFIG);

// *** led_lamps.sv ***
// model of the three indicator lamps, lit while their line is low
`timescale 1ns/100ps
module led_lamps (
  input wire logic [2:0] led_n, // lamp lines
  output logic [2:0] lit // lamp lit
);
  assign lit = ~led_n;
endmodule

// *** phy_status_led_driver_test.sv ***
// self-checking bench for the status indicator driver
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %s exp %0h got %0h", n, e, a); end end
module phy_status_led_driver_test;
  import phy_led_pkg::*;
  logic clk = 0, rst = 1, lk = 0, fd = 0, sp = 0, col = 0, tx = 0, rx = 0, fl, sl, al;
  logic [2:0] cfg_in = 3'h5, cfg, lit;
  logic ts = 0;
  logic [1:0] tdiv = 2'h0;
  int miscompares = 0, comparisons = 0, n;
  initial forever #10 clk = ~clk;
  // test clock pin: rises once every four core cycles
  always @(posedge clk) tdiv <= tdiv + 2'h1;
  phy_status_led_driver #(.BLINK_TICKS(21'h4)) u_dut (.CORE_CLK(clk), .RST(rst), .LINK_UP(lk),
    .FULL_DUPLEX(fd), .SPEED_100(sp), .COLLISION(col), .TX_ACTIVITY(tx), .RX_ACTIVITY(rx),
    .TEST_CLOCK_IN(tdiv[1]), .TEST_CLOCK_SELECT(ts), .CONFIG_IN(cfg_in),
    .FULL_COLLISION_LED_N(fl), .SPEED_LED_N(sl), .LINK_ACTIVITY_LED_N(al), .CONFIG(cfg));
  led_lamps u_lamps (.led_n({fl, sl, al}), .lit(lit));
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // waits for lamp b to reach level v, then counts cycles it stays there
  task automatic run(input int b, input logic v, output int k);
    k = 0;
    for (int i = 0; i < 40 && lit[b] !== v; i++) @(negedge clk);
    while (k < 40 && lit[b] === v) begin k++; @(negedge clk); end
  endtask
  task automatic t_reset();
    @(negedge clk);
    `CHK("reset lamps", 3'h0, lit)
    @(posedge clk) rst <= 0;
    repeat (2) @(negedge clk);
    `CHK("setting", 3'h5, cfg)
    $display("reset test done");
  endtask
  task automatic t_status();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) {lk, fd, sp} <= i[2:0];
      repeat (2) @(negedge clk);
      `CHK("full lamp", i[2] & i[1], lit[2])
      `CHK("speed lamp", i[2] & i[0], lit[1])
      `CHK("link lamp", i[2], lit[0])
    end
    $display("status test done");
  endtask
  task automatic t_col();
    @(posedge clk) fd <= 0;
    repeat (11) @(posedge clk);
    col <= 1;
    run(2, 1, n);
    `CHK("collision pulse", 1'b1, n inside {[7:9]})
    run(2, 0, n);
    `CHK("collision gap", 1'b1, n inside {[7:9]})
    @(posedge clk) col <= 0;
    $display("collision test done");
  endtask
  task automatic t_act();
    @(posedge clk) tx <= 1;
    @(posedge clk) tx <= 0;
    run(0, 0, n);
    `CHK("activity pulse", 1'b1, n inside {[7:9]})
    @(posedge clk) rx <= 1;
    run(0, 1, n);
    `CHK("activity gap", 1'b1, n inside {[7:9]})
    run(0, 0, n);
    `CHK("second pulse", 1'b1, n inside {[7:9]})
    @(posedge clk) rx <= 0;
    $display("activity test done");
  endtask
  // with the test time base, 4 ticks of 4 core cycles make a 13 to 16 cycle pulse
  task automatic t_test_clock_in();
    repeat (20) @(posedge clk);
    ts <= 1;
    repeat (10) @(posedge clk);
    tx <= 1;
    @(posedge clk) tx <= 0;
    run(0, 0, n);
    `CHK("test clock pulse", 1'b1, n inside {[13:16]})
    repeat (40) @(posedge clk);
    ts <= 0;
    repeat (10) @(posedge clk);
    $display("test clock test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    t_reset();
    t_status();
    t_col();
    t_act();
    t_test_clock_in();
    give_verdict();
  end
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule
